// ### common/rfsel_pkg.sv
package rfsel_pkg;
  // apb register byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ARBMEM = 8'h08;
  localparam logic [ADDR_W-1:0] REG_GRPRX = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_TAGCODE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FAMILY = 8'h14;
  localparam logic [ADDR_W-1:0] REG_PTRDATA = 8'h18;
  localparam logic [ADDR_W-1:0] REG_CRCRES = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_XFER = 8'h20;
  localparam int DATA_W = 32;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int OP_W = 6;
  localparam int CMD_SEL_BIT = 6;
  localparam int CMD_CRC_BIT = 7;
  localparam int CMD_ISO_BIT = 8;
  localparam int CMD_NBYTE_LSB = 9;
  localparam int CRCRES_OK_BIT = 0;

  // command codes
  localparam logic [OP_W-1:0] OP_RESET_STATUS = 6'h01;
  localparam logic [OP_W-1:0] OP_RESET_GLOBAL = 6'h02;
  localparam logic [OP_W-1:0] OP_GROUP_TAGCODE = 6'h04;
  localparam logic [OP_W-1:0] OP_GROUP_FAMILY = 6'h05;
  localparam logic [OP_W-1:0] OP_GROUP_PTR = 6'h06;
  localparam logic [OP_W-1:0] OP_GROUP_PTR_LEQ = 6'h07;
  localparam logic [OP_W-1:0] OP_GROUP_PTR_GEQ = 6'h08;
  localparam logic [OP_W-1:0] OP_ARB_TAGCODE = 6'h0A;
  localparam logic [OP_W-1:0] OP_ARB_PTR = 6'h0B;
  localparam logic [OP_W-1:0] OP_ARB_PTR_RAND = 6'h0C;
  localparam logic [OP_W-1:0] OP_FETCH_WORD = 6'h10;
  localparam logic [OP_W-1:0] OP_FETCH_WORD_CTRL = 6'h11;
  localparam logic [OP_W-1:0] OP_FETCH_BLOCK = 6'h12;
  localparam logic [OP_W-1:0] OP_FETCH_BLOCK_CTRL = 6'h13;
  localparam logic [OP_W-1:0] OP_WRITE_WORD = 6'h14;
  localparam logic [OP_W-1:0] OP_WRITE_WORD_CTRL = 6'h15;
  localparam logic [OP_W-1:0] OP_WRITE_NBYTE = 6'h16;
  localparam logic [OP_W-1:0] OP_FETCH_PAGE = 6'h18;
  localparam logic [OP_W-1:0] OP_FETCH_SYSINFO = 6'h19;
  localparam logic [OP_W-1:0] OP_CENSUS_SEL = 6'h1A;
  localparam logic [OP_W-1:0] OP_CENSUS_UNSEL = 6'h1B;
  localparam logic [OP_W-1:0] OP_REPEAT_ARB = 6'h1C;
  localparam logic [OP_W-1:0] OP_SLOT = 6'h20;
  localparam logic [OP_W-1:0] OP_SLOT_SEL = 6'h21;
  localparam logic [OP_W-1:0] OP_SLOT_NOTSEL = 6'h22;
  localparam logic [OP_W-1:0] OP_SLOT_REPEAT = 6'h23;
  localparam logic [OP_W-1:0] OP_SKIP_SLOT = 6'h24;
  localparam logic [OP_W-1:0] OP_SLOT_CLOSE = 6'h25;

  // status register fields
  localparam int ST_GROUP = 0;
  localparam int ST_WON = 1;
  localparam int ST_ISO = 2;
  localparam int ST_LOST = 3;
  localparam int ST_TRIG = 4;
  localparam int ST_ALOHA = 5;
  localparam int ST_ACTIVE = 6;
  localparam int ST_SLOT_LSB = 8;
  localparam int ST_RSLOT_LSB = 16;
  localparam int ST_WAKE_LSB = 24;
  localparam int ST_ARB_LSB = 28;

  // transfer register fields
  localparam int XF_BITS_W = 10;
  localparam int XF_CTRL_BIT = 10;
  localparam int XF_WRITE_BIT = 11;
  localparam int XF_LOOP_BIT = 12;

  // answer lengths in bits
  localparam logic [XF_BITS_W-1:0] LEN_WORD = 10'd32;
  localparam logic [XF_BITS_W-1:0] LEN_BLOCK = 10'd128;
  localparam logic [XF_BITS_W-1:0] LEN_SYSINFO = 10'd328;
  localparam logic [XF_BITS_W-1:0] LEN_CENSUS = 10'd40;
  localparam logic [XF_BITS_W-1:0] BITS_PER_BYTE = 10'd8;
  localparam int NBYTE_W = 2;

  // slots and random source
  localparam int SLOT_W = 5;
  localparam int WAKE_W = 4;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // trigger setting and sub-carrier half periods
  localparam int TRIG_ON_BIT = 1;
  localparam int TRIG_DIV_BIT = 0;
  localparam logic [1:0] HALF_DIV4 = 2'd1;
  localparam logic [1:0] HALF_DIV8 = 2'd3;

  typedef enum logic [2:0] {
    ARB_IDLE = 3'b000,
    ARB_HDR = 3'b001,
    ARB_REF = 3'b011,
    ARB_BITS = 3'b010,
    ARB_CRC = 3'b110
  } rfsel_arb_e;
endpackage : rfsel_pkg

// ### logic/rfsel_sync3.sv
module rfsel_sync3 (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // pin in, clean level and rising pulse out
  input wire logic pinIn,
  output logic level,
  output logic rise
);
  logic s1_r, s2_r, s3_r, lvl_r;
  logic lvl_nxt;

  // change is accepted only when stage two and three agree
  always_comb begin
    lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
  end

  // three flop chain
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      lvl_r <= 1'b0;
    end else if (ce) begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign level = lvl_r;
  assign rise = lvl_nxt & ~lvl_r & ce;
endmodule : rfsel_sync3

// ### logic/rfsel_tag_ctrl.sv
// Function
// - arbitration bit: interval shorter than header reference is zero, else one
// - mismatch with stored bit drops tag out, silent, no reads or writes
// - group mark changed only by group commands, also cleared by reset
// - group compare supports equal on three sources, greater-or-equal and less-or-equal on pointer data only
// - arbitration-won set only after full frame won and crc good
// - reset clears arbitration-won; group loss clears it under select condition
// - won and isolated flags live in the selection status register
// - end-of-field symbol ends arbitration data and starts crc section
// - arbitration-repeat re-runs last long arbitration or group command
// - trigger setting loaded after reset: 0x off, 10 osc/4, 11 osc/8
// - sub-carrier runs until a notch starts the forward stream
// - global reset command re-enables trigger from stored setting
// - group commands leave isolated flag alone; won cleared only on a loss under select
// - the three anticollision commands update won and isolated flags
// - reads loop 32 or 128 bits from user or control memory
// - full-word writes take 32 bits; variable write takes one to four bytes
// - census commands answer in one of 16 slots with code plus 8 bits
// - slot variants pick participants by flags; most affect isolated flag
// - skip-slot advances slot counter, isolated flag unchanged; slot-repeat changes neither
// - temporary command not enabled answers with an error code
// - unknown code with good crc changes nothing and never blocks
// - system-information read gives 8 status bits plus 320 memory bits
// - select condition set: needs group mark or won, not isolated
// - isolated flag cleared only by power-on or reset command
// - slot command draws 0..31 from free random source, answers on match
//
// The register offsets and the APB register port were left to the implementer.
module rfsel_tag_ctrl #(
  parameter int CNT_W = 16
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rfsel_pkg::ADDR_W-1:0] paddr,
  input wire logic [rfsel_pkg::DATA_W-1:0] pwdata,
  output logic [rfsel_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // field and memory side
  input wire logic notchPin,
  input wire logic [1:0] trigSetting,
  output logic subCarrier,
  output logic answerStrobe,
  output logic errorStrobe
);
  import rfsel_pkg::*;

  // apb state
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [DATA_W-1:0] prdata_r, prdata_nxt;
  // configuration registers
  logic [DATA_W-1:0] arbMem_r, arbMem_nxt, grpRx_r, grpRx_nxt;
  logic [DATA_W-1:0] tagCode_r, tagCode_nxt, family_r, family_nxt, ptrData_r, ptrData_nxt;
  // selection state
  logic groupMark_r, groupMark_nxt, arbWon_r, arbWon_nxt, isolated_r, isolated_nxt;
  logic arbLost_r, arbLost_nxt, isoOnWin_r, isoOnWin_nxt;
  rfsel_arb_e arbSt_r, arbSt_nxt;
  logic [CNT_W-1:0] intCnt_r, intCnt_nxt, refTime_r, refTime_nxt;
  logic [4:0] bitIdx_r, bitIdx_nxt;
  logic [DATA_W-1:0] arbPat_r, arbPat_nxt;
  logic lastValid_r, lastValid_nxt, lastSel_r, lastSel_nxt;
  logic [OP_W-1:0] lastOp_r, lastOp_nxt;
  logic alohaRun_r, alohaRun_nxt, alohaElig_r, alohaElig_nxt;
  logic [OP_W-1:0] lastAloha_r, lastAloha_nxt;
  logic [SLOT_W-1:0] slotNum_r, slotNum_nxt, readerSlot_r, readerSlot_nxt;
  logic [WAKE_W-1:0] wakeSlot_r, wakeSlot_nxt;
  logic [15:0] lfsr_r, lfsr_nxt;
  logic [XF_BITS_W+2:0] xfer_r, xfer_nxt;
  logic active_r, active_nxt, answer_r, answer_nxt, err_r, err_nxt;
  // trigger state
  logic cfgLoad_r, cfgLoad_nxt, trigOn_r, trigOn_nxt, trigDiv_r, trigDiv_nxt;
  logic [1:0] subCnt_r, subCnt_nxt;
  logic sub_r, sub_nxt;
  // helpers
  logic notchLevel, notchRise, wrEn, cmdGo, isTemp, cmdElig, slotMatch, rxBit, isEof;
  logic [OP_W-1:0] op;
  logic sel, grpPass;
  logic [DATA_W-1:0] grpSrc;
  logic [CNT_W:0] eofLim;

  // notch pin enters through the three-flop filter
  rfsel_sync3 notchSync (
    .mclk(mclk),
    .resetn(resetn),
    .ce(ce),
    .pinIn(notchPin),
    .level(notchLevel),
    .rise(notchRise)
  );

  // apb slave: one setup, one access cycle, no waits
  always_comb begin
    pready_nxt = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = '0;
    if (psel && !penable) begin
      if (paddr == REG_CMD) begin
        prdata_nxt = {lastValid_r, 24'h000000, lastSel_r, lastOp_r};
      end else if (paddr == REG_STATUS) begin
        prdata_nxt[ST_GROUP] = groupMark_r;
        prdata_nxt[ST_WON] = arbWon_r;
        prdata_nxt[ST_ISO] = isolated_r;
        prdata_nxt[ST_LOST] = arbLost_r;
        prdata_nxt[ST_TRIG] = trigOn_r;
        prdata_nxt[ST_ALOHA] = alohaRun_r;
        prdata_nxt[ST_ACTIVE] = active_r;
        prdata_nxt[ST_SLOT_LSB +: SLOT_W] = slotNum_r;
        prdata_nxt[ST_RSLOT_LSB +: SLOT_W] = readerSlot_r;
        prdata_nxt[ST_WAKE_LSB +: WAKE_W] = wakeSlot_r;
        prdata_nxt[ST_ARB_LSB +: 3] = arbSt_r;
      end else if (paddr == REG_ARBMEM) begin
        prdata_nxt = arbMem_r;
      end else if (paddr == REG_GRPRX) begin
        prdata_nxt = grpRx_r;
      end else if (paddr == REG_TAGCODE) begin
        prdata_nxt = tagCode_r;
      end else if (paddr == REG_FAMILY) begin
        prdata_nxt = family_r;
      end else if (paddr == REG_PTRDATA) begin
        prdata_nxt = ptrData_r;
      end else if (paddr == REG_CRCRES) begin
        prdata_nxt = '0;
      end else if (paddr == REG_XFER) begin
        prdata_nxt[XF_BITS_W+2:0] = xfer_r;
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end else if (ce) begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // write strobe and effective command (repeat re-uses the stored one)
  assign wrEn = psel & penable & pready_r & pwrite & ~pslverr_r;
  assign cmdGo = wrEn && paddr == REG_CMD && pwdata[CMD_CRC_BIT];
  assign isTemp = pwdata[CMD_OP_LSB +: OP_W] == OP_REPEAT_ARB;
  assign op = (isTemp && lastValid_r) ? lastOp_r : pwdata[CMD_OP_LSB +: OP_W];
  assign sel = (isTemp && lastValid_r) ? lastSel_r : pwdata[CMD_SEL_BIT];
  assign cmdElig = (sel ? (groupMark_r | arbWon_r) : 1'b1) & ~isolated_r;
  assign slotMatch = alohaElig_r && slotNum_r == readerSlot_r;
  assign rxBit = intCnt_r >= refTime_r;
  assign eofLim = {1'b0, refTime_r} + {1'b0, refTime_r};
  assign isEof = {1'b0, intCnt_r} >= eofLim;

  // group comparison source and test
  always_comb begin
    grpSrc = ptrData_r;
    if (op == OP_GROUP_TAGCODE) begin
      grpSrc = tagCode_r;
    end else if (op == OP_GROUP_FAMILY) begin
      grpSrc = family_r;
    end
    grpPass = grpRx_r == grpSrc;
    if (op == OP_GROUP_PTR_LEQ) begin
      grpPass = grpRx_r <= grpSrc;
    end else if (op == OP_GROUP_PTR_GEQ) begin
      grpPass = grpRx_r >= grpSrc;
    end
  end

  // selection, arbitration and command execution
  always_comb begin
    arbMem_nxt = arbMem_r;
    grpRx_nxt = grpRx_r;
    tagCode_nxt = tagCode_r;
    family_nxt = family_r;
    ptrData_nxt = ptrData_r;
    groupMark_nxt = groupMark_r;
    arbWon_nxt = arbWon_r;
    isolated_nxt = isolated_r;
    arbLost_nxt = arbLost_r;
    isoOnWin_nxt = isoOnWin_r;
    arbSt_nxt = arbSt_r;
    intCnt_nxt = (&intCnt_r) ? intCnt_r : intCnt_r + 1'b1;
    refTime_nxt = refTime_r;
    bitIdx_nxt = bitIdx_r;
    arbPat_nxt = arbPat_r;
    lastValid_nxt = lastValid_r;
    lastSel_nxt = lastSel_r;
    lastOp_nxt = lastOp_r;
    alohaRun_nxt = alohaRun_r;
    alohaElig_nxt = alohaElig_r;
    lastAloha_nxt = lastAloha_r;
    slotNum_nxt = slotNum_r;
    readerSlot_nxt = readerSlot_r;
    wakeSlot_nxt = wakeSlot_r;
    xfer_nxt = xfer_r;
    active_nxt = alohaRun_r ? slotMatch : active_r;
    answer_nxt = 1'b0;
    err_nxt = 1'b0;
    lfsr_nxt = lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
    if (wrEn) begin
      if (paddr == REG_ARBMEM) begin
        arbMem_nxt = pwdata;
      end else if (paddr == REG_GRPRX) begin
        grpRx_nxt = pwdata;
      end else if (paddr == REG_TAGCODE) begin
        tagCode_nxt = pwdata;
      end else if (paddr == REG_FAMILY) begin
        family_nxt = pwdata;
      end else if (paddr == REG_PTRDATA) begin
        ptrData_nxt = pwdata;
      end
    end
    // arbitration frame on notch intervals
    if (notchRise) begin
      intCnt_nxt = '0;
    end
    case (arbSt_r)
      ARB_HDR: begin
        if (notchRise) begin
          arbSt_nxt = ARB_REF;
        end
      end
      ARB_REF: begin
        if (notchRise) begin
          refTime_nxt = intCnt_r;
          arbSt_nxt = ARB_BITS;
        end
      end
      ARB_BITS: begin
        if (notchRise) begin
          if (isEof) begin
            arbSt_nxt = ARB_CRC;
          end else if (rxBit != arbPat_r[bitIdx_r]) begin
            arbLost_nxt = 1'b1;
            arbWon_nxt = 1'b0;
            arbSt_nxt = ARB_IDLE;
          end else begin
            bitIdx_nxt = bitIdx_r - 1'b1;
          end
        end
      end
      ARB_CRC: begin
        if (wrEn && paddr == REG_CRCRES) begin
          arbWon_nxt = pwdata[CRCRES_OK_BIT];
          isolated_nxt = isolated_r | (pwdata[CRCRES_OK_BIT] & isoOnWin_r);
          arbSt_nxt = ARB_IDLE;
        end
      end
      default: begin
        arbSt_nxt = ARB_IDLE;
      end
    endcase
    if (cmdGo) begin
      if (isTemp && !lastValid_r) begin
        err_nxt = 1'b1;
      end else if (op == OP_RESET_STATUS || op == OP_RESET_GLOBAL) begin
        groupMark_nxt = 1'b0;
        arbWon_nxt = 1'b0;
        isolated_nxt = 1'b0;
        arbLost_nxt = 1'b0;
        alohaRun_nxt = 1'b0;
        alohaElig_nxt = 1'b0;
        active_nxt = 1'b0;
        arbSt_nxt = ARB_IDLE;
      end else if (op == OP_SKIP_SLOT) begin
        if (alohaRun_r) begin
          readerSlot_nxt = readerSlot_r + 1'b1;
          if (slotMatch) begin
            slotNum_nxt = lfsr_r[SLOT_W-1:0];
          end
          answer_nxt = alohaElig_r;
        end else begin
          err_nxt = 1'b1;
        end
      end else if (op >= OP_SLOT && op <= OP_SLOT_CLOSE) begin
        if (op == OP_SLOT_REPEAT) begin
          answer_nxt = slotMatch;
        end else if (!alohaRun_r && op != OP_SLOT_CLOSE) begin
          alohaRun_nxt = 1'b1;
          lastAloha_nxt = op;
          readerSlot_nxt = '0;
          slotNum_nxt = lfsr_r[SLOT_W-1:0];
          alohaElig_nxt = ~isolated_r;
          if (op == OP_SLOT_SEL) begin
            alohaElig_nxt = (arbWon_r | groupMark_r) & ~isolated_r;
          end else if (op == OP_SLOT_NOTSEL) begin
            alohaElig_nxt = ~arbWon_r & ~groupMark_r & ~isolated_r;
          end
        end else begin
          if (slotMatch) begin
            isolated_nxt = 1'b1;
            alohaElig_nxt = 1'b0;
          end
          readerSlot_nxt = readerSlot_r + 1'b1;
          if (op == OP_SLOT_CLOSE) begin
            alohaRun_nxt = 1'b0;
            active_nxt = 1'b0;
          end
        end
      end else if (op == OP_CENSUS_SEL || op == OP_CENSUS_UNSEL) begin
        wakeSlot_nxt = lfsr_r[WAKE_W-1:0];
        xfer_nxt = {3'b000, LEN_CENSUS};
        answer_nxt = ~isolated_r & ((arbWon_r | groupMark_r) ^ (op == OP_CENSUS_UNSEL));
      end else if (cmdElig) begin
        if (op >= OP_GROUP_TAGCODE && op <= OP_GROUP_PTR_GEQ) begin
          groupMark_nxt = grpPass;
          if (sel && !grpPass) begin
            arbWon_nxt = 1'b0;
          end
          lastValid_nxt = 1'b1;
          lastOp_nxt = op;
          lastSel_nxt = sel;
          answer_nxt = 1'b1;
        end else if (op >= OP_ARB_TAGCODE && op <= OP_ARB_PTR_RAND) begin
          arbLost_nxt = 1'b0;
          arbSt_nxt = ARB_HDR;
          bitIdx_nxt = 5'h1F;
          arbPat_nxt = (op == OP_ARB_PTR_RAND) ? {lfsr_r, lfsr_r} : arbMem_r;
          arbPat_nxt = (op == OP_ARB_TAGCODE) ? tagCode_r : arbPat_nxt;
          isoOnWin_nxt = isTemp ? isoOnWin_r : pwdata[CMD_ISO_BIT];
          lastValid_nxt = 1'b1;
          lastOp_nxt = op;
          lastSel_nxt = sel;
        end else if (op >= OP_FETCH_WORD && op <= OP_FETCH_SYSINFO && !arbLost_r) begin
          answer_nxt = 1'b1;
          active_nxt = 1'b1;
          case (op)
            OP_FETCH_WORD, OP_FETCH_WORD_CTRL: begin
              xfer_nxt = {1'b1, 1'b0, op[0], LEN_WORD};
            end
            OP_FETCH_BLOCK, OP_FETCH_BLOCK_CTRL: begin
              xfer_nxt = {1'b1, 1'b0, op[0], LEN_BLOCK};
            end
            OP_FETCH_PAGE: begin
              xfer_nxt = {1'b1, 1'b0, 1'b1, LEN_BLOCK};
            end
            OP_FETCH_SYSINFO: begin
              xfer_nxt = {1'b0, 1'b0, 1'b1, LEN_SYSINFO};
            end
            OP_WRITE_WORD, OP_WRITE_WORD_CTRL: begin
              xfer_nxt = {1'b0, 1'b1, op[0], LEN_WORD};
            end
            OP_WRITE_NBYTE: begin
              xfer_nxt = {1'b0, 1'b1, 1'b0, XF_BITS_W'(({8'h00, pwdata[CMD_NBYTE_LSB +: NBYTE_W]} + 10'd1)
                * BITS_PER_BYTE)};
            end
            default: begin
              answer_nxt = 1'b0;
              active_nxt = active_r;
            end
          endcase
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      arbMem_r <= '0;
      grpRx_r <= '0;
      tagCode_r <= '0;
      family_r <= '0;
      ptrData_r <= '0;
      groupMark_r <= 1'b0;
      arbWon_r <= 1'b0;
      isolated_r <= 1'b0;
      arbLost_r <= 1'b0;
      isoOnWin_r <= 1'b0;
      arbSt_r <= ARB_IDLE;
      intCnt_r <= '0;
      refTime_r <= '0;
      bitIdx_r <= '0;
      arbPat_r <= '0;
      lastValid_r <= 1'b0;
      lastSel_r <= 1'b0;
      lastOp_r <= '0;
      alohaRun_r <= 1'b0;
      alohaElig_r <= 1'b0;
      lastAloha_r <= '0;
      slotNum_r <= '0;
      readerSlot_r <= '0;
      wakeSlot_r <= '0;
      lfsr_r <= LFSR_SEED;
      xfer_r <= '0;
      active_r <= 1'b0;
      answer_r <= 1'b0;
      err_r <= 1'b0;
    end else if (ce) begin
      arbMem_r <= arbMem_nxt;
      grpRx_r <= grpRx_nxt;
      tagCode_r <= tagCode_nxt;
      family_r <= family_nxt;
      ptrData_r <= ptrData_nxt;
      groupMark_r <= groupMark_nxt;
      arbWon_r <= arbWon_nxt;
      isolated_r <= isolated_nxt;
      arbLost_r <= arbLost_nxt;
      isoOnWin_r <= isoOnWin_nxt;
      arbSt_r <= arbSt_nxt;
      intCnt_r <= intCnt_nxt;
      refTime_r <= refTime_nxt;
      bitIdx_r <= bitIdx_nxt;
      arbPat_r <= arbPat_nxt;
      lastValid_r <= lastValid_nxt;
      lastSel_r <= lastSel_nxt;
      lastOp_r <= lastOp_nxt;
      alohaRun_r <= alohaRun_nxt;
      alohaElig_r <= alohaElig_nxt;
      lastAloha_r <= lastAloha_nxt;
      slotNum_r <= slotNum_nxt;
      readerSlot_r <= readerSlot_nxt;
      wakeSlot_r <= wakeSlot_nxt;
      lfsr_r <= lfsr_nxt;
      xfer_r <= xfer_nxt;
      active_r <= active_nxt;
      answer_r <= answer_nxt;
      err_r <= err_nxt;
    end
  end

  // trigger: setting caught after reset release, sub-carrier until first notch
  always_comb begin
    cfgLoad_nxt = 1'b0;
    trigOn_nxt = trigOn_r;
    trigDiv_nxt = trigDiv_r;
    subCnt_nxt = subCnt_r + 1'b1;
    sub_nxt = sub_r;
    if (cfgLoad_r) begin
      trigOn_nxt = trigSetting[TRIG_ON_BIT];
      trigDiv_nxt = trigSetting[TRIG_DIV_BIT];
      subCnt_nxt = '0;
    end else if (notchRise) begin
      trigOn_nxt = 1'b0;
    end
    if (cmdGo && op == OP_RESET_GLOBAL && !isTemp) begin
      cfgLoad_nxt = 1'b1;
    end
    if (!trigOn_r) begin
      sub_nxt = 1'b0;
    end else if (subCnt_r == (trigDiv_r ? HALF_DIV8 : HALF_DIV4)) begin
      sub_nxt = ~sub_r;
      subCnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cfgLoad_r <= 1'b1;
      trigOn_r <= 1'b0;
      trigDiv_r <= 1'b0;
      subCnt_r <= '0;
      sub_r <= 1'b0;
    end else if (ce) begin
      cfgLoad_r <= cfgLoad_nxt;
      trigOn_r <= trigOn_nxt;
      trigDiv_r <= trigDiv_nxt;
      subCnt_r <= subCnt_nxt;
      sub_r <= sub_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign subCarrier = sub_r;
  assign answerStrobe = answer_r;
  assign errorStrobe = err_r;
endmodule : rfsel_tag_ctrl

// ### testbench/rfid_tag_selection_control_bench.sv
module rfid_tag_selection_control_bench;
  import rfsel_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, notch, pready, pslverr, sub, ans, errS, err, gm, ce = 1;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h1F, m, v;
  logic [1:0] trig = 2'b10;
  int badCount = 0, cmpCount = 0, ansCnt = 0, errCnt = 0;
  // clock and strobe tally
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    ansCnt += int'(ans === 1'b1);
    errCnt += int'(errS === 1'b1);
  end
  rfsel_tag_ctrl rfsel_tag_ctrl_i (.mclk(mclk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .notchPin(notch), .trigSetting(trig), .subCarrier(sub), .answerStrobe(ans), .errorStrobe(errS));
  rfsel_reader rfsel_reader_i (.mclk(mclk), .notch(notch));
  // helpers
  function logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction : xs
  function logic [31:0] cmd(input logic [5:0] op, input logic iso);
    return {23'h0, iso, 1'b1, 1'b0, op};
  endfunction : cmd
  function logic [31:0] flags(input logic g, input logic w, input logic i);
    return {29'h0, i, w, g};
  endfunction : flags
  // group compare outcome: op 7 less-or-equal, op 8 greater-or-equal, others equal
  function logic grp(input int op, input logic [31:0] r, input logic [31:0] s);
    return (op == 7) ? (r <= s) : ((op == 8) ? (r >= s) : (r == s));
  endfunction : grp
  task cmp(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task st;
    apb(1'b0, REG_STATUS, 32'h0);
  endtask : st
  task bits(input logic [31:0] p, input int n);
    rfsel_reader_i.pulse(5);
    rfsel_reader_i.pulse(20);
    for (int k = 31; k > 31 - n; k--) rfsel_reader_i.pulse(p[k] ? 28 : 8);
  endtask : bits
  task win(input logic iso);
    m = xs(seed); seed = m;
    apb(1'b1, REG_TAGCODE, m);
    apb(1'b1, REG_CMD, cmd(OP_ARB_TAGCODE, iso));
    bits(m, 8);
    rfsel_reader_i.pulse(50);
    apb(1'b1, REG_CRCRES, 32'h1);
    st;
  endtask : win
  task giveVerdict;
    $display("mismatches %0d compares %0d", badCount, cmpCount);
    if (badCount == 0 && cmpCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : giveVerdict
  // watchdog
  initial begin
    #300000;
    badCount++;
    giveVerdict();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    st;
    cmp(rd[ST_TRIG], 1);
    // code 10: sub-carrier toggles every second cycle
    repeat (2) begin
      v = sub;
      repeat (2) @(posedge mclk);
      cmp(sub, !v[0]);
    end
    // clock enable low freezes the sub-carrier
    ce <= 1'b0;
    @(posedge mclk);
    v = sub;
    repeat (2) @(posedge mclk);
    cmp(sub, v);
    ce <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    cmp(err, 1);
    win(1'b0);
    cmp(rd[2:0], flags(0, 1, 0));
    cmp(rd[ST_TRIG], 0);
    apb(1'b1, REG_CMD, cmd(OP_ARB_TAGCODE, 1'b0));
    bits(~m, 1);
    st;
    cmp({rd[ST_LOST], rd[ST_WON]}, 2'b10);
    v = ansCnt;
    apb(1'b1, REG_CMD, cmd(OP_FETCH_WORD, 1'b0));
    st;
    cmp(ansCnt, v);
    win(1'b1);
    cmp(rd[2:0], flags(0, 1, 1));
    apb(1'b1, REG_CMD, cmd(OP_RESET_STATUS, 1'b0));
    st;
    cmp(rd[2:0], flags(0, 0, 0));
    win(1'b0);
    cmp(rd[2:0], flags(0, 1, 0));
    apb(1'b1, REG_CMD, cmd(OP_FETCH_BLOCK_CTRL, 1'b0));
    apb(1'b0, REG_XFER, 32'h0);
    cmp(rd[12:0], {3'b101, LEN_BLOCK});
    v = xs(seed); seed = v;
    for (int a = REG_TAGCODE; a <= REG_PTRDATA; a += 4) apb(1'b1, a[7:0], v);
    // random received values, an equal one on op 5, a losing one under select on op 8
    for (int op = 4; op <= 8; op++) begin
      m = xs(seed); seed = m;
      if (op == 5) m = v;
      if (op == 8) m = v - 1;
      gm = grp(op, m, v);
      apb(1'b1, REG_GRPRX, m);
      apb(1'b1, REG_CMD, cmd(op[5:0], 1'b0) | (32'(op == 8) << CMD_SEL_BIT));
      st;
      cmp(rd[2:0], flags(gm, op != 8 || gm, 1'b0));
    end
    v = errCnt;
    apb(1'b1, REG_CMD, cmd(OP_SKIP_SLOT, 1'b0));
    apb(1'b1, REG_CMD, cmd(6'h3F, 1'b0));
    st;
    cmp(errCnt, v + 1);
    cmp(rd[2:0], flags(0, 0, 0));
    apb(1'b1, REG_CMD, cmd(OP_RESET_GLOBAL, 1'b0));
    repeat (3) @(posedge mclk);
    st;
    cmp(rd[ST_TRIG], 1);
    giveVerdict();
  end
endmodule : rfid_tag_selection_control_bench

// ### testbench/rfsel_reader.sv
module rfsel_reader (
  // clock
  input wire logic mclk,
  // notch line, idles low between frames
  output logic notch
);
  timeunit 1ns;
  timeprecision 1ps;
  initial notch = 1'b0;
  // one notch after a gap, rise to rise n+4 cycles
  task pulse(input int n);
    repeat (n) @(posedge mclk);
    notch <= 1'b1;
    repeat (4) @(posedge mclk);
    notch <= 1'b0;
  endtask : pulse
endmodule : rfsel_reader

// ### testbench/rfsel_tag_ctrl_monitor.sv
module rfsel_tag_ctrl_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // field side
  input wire logic notchPin,
  input wire logic subCarrier,
  input wire logic answerStrobe,
  input wire logic errorStrobe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("pready late");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_ready_one_cycle: assert property (pready |=> !pready) else $error("pready stuck");
  a_err_unmapped: assert property (pready && paddr > 8'h20 |-> pslverr) else $error("no slave error");
  a_err_zero_data: assert property (pslverr |-> prdata == 32'h0) else $error("error data not zero");
  a_error_from_cmd: assert property (errorStrobe |-> $past(pready && pwrite && paddr == 8'h00))
    else $error("error strobe without command");
  a_strobe_excl: assert property (!(answerStrobe && errorStrobe)) else $error("answer and error");
  a_notch_stops_trig: assert property ($rose(notchPin) |-> ##8 !subCarrier [*4])
    else $error("sub-carrier kept running");
endmodule : rfsel_tag_ctrl_monitor

bind rfsel_tag_ctrl rfsel_tag_ctrl_monitor mon_i (.mclk(mclk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .notchPin(notchPin), .subCarrier(subCarrier), .answerStrobe(answerStrobe), .errorStrobe(errorStrobe));
